// ==== core/pgotm_top.sv ====
module pgotm_top #(
  parameter int VARIANT = 0
) (
  // Clock and reset
  input  wire logic                  MCLK_I,
  input  wire logic                  RESET_N_I,
  // Register access port
  input  wire pgotm_pkg::pgotm_req_t REG_REQ_I,
  output pgotm_pkg::pgotm_rsp_t      REG_RSP_O,
  // Rail power-good flags, same clock domain
  input  wire logic                  STEP_DOWN_ONE_PG_I,
  input  wire logic                  STEP_DOWN_TWO_PG_I,
  input  wire logic                  STEP_DOWN_THREE_PG_I,
  input  wire logic                  STEP_DOWN_FOUR_PG_I,
  input  wire logic                  STEP_DOWN_FIVE_PG_I,
  input  wire logic                  STEP_DOWN_SIX_PG_I,
  input  wire logic                  LOAD_SWITCH_A_ONE_PG_I,
  input  wire logic                  LINEAR_REG_TWO_PG_I,
  input  wire logic                  LINEAR_REG_THREE_PG_I,
  input  wire logic                  LOAD_SWITCH_B_ONE_PG_I,
  input  wire logic                  SHARED_SWITCH_OR_LINEAR_RAIL_PG_I,
  input  wire logic                  DDR_TERMINATION_REG_PG_I,
  // Control input pins, asynchronous
  input  wire logic                  CONTROL_INPUT_ONE_I,
  input  wire logic                  CONTROL_INPUT_TWO_I,
  input  wire logic                  CONTROL_INPUT_FOUR_I,
  input  wire logic                  CONTROL_INPUT_FIVE_I,
  // Power-good output and registered mask copies
  output logic                       STATUS_OUTPUT_THREE_O,
  output logic [7:0]                 RAIL_MASK_O,
  output logic [7:0]                 MISC_MASK_O
);

  // ----------------------------------------------------------------
  // Control pin synchronisation
  // ----------------------------------------------------------------
  logic [3:0] ctl_raw;
  logic [3:0] ctl_sync;

  assign ctl_raw = {CONTROL_INPUT_FIVE_I, CONTROL_INPUT_FOUR_I,
                    CONTROL_INPUT_TWO_I, CONTROL_INPUT_ONE_I};

  pgotm_sync #(
    .WIDTH (4)
  ) u_ctl_sync (
    .clk_i   (MCLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     (ctl_raw),
    .q_o     (ctl_sync)
  );

  // ----------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------
  localparam logic [7:0] RAIL_RST = pgotm_pkg::RAIL_RESET[VARIANT];
  localparam logic [7:0] MISC_RST = pgotm_pkg::MISC_RESET[VARIANT];

  logic [7:0] rail_mask_q;
  logic [7:0] rail_mask_d;
  logic [7:0] misc_mask_q;
  logic [7:0] misc_mask_d;
  wire        hit_rail;
  wire        hit_misc;
  wire        wr_rail;
  wire        wr_misc;

  assign hit_rail    = REG_REQ_I.addr == pgotm_pkg::RAIL_MASK_ADDR;
  assign hit_misc    = REG_REQ_I.addr == pgotm_pkg::MISC_MASK_ADDR;
  assign wr_rail     = REG_REQ_I.wr_en && hit_rail;
  assign wr_misc     = REG_REQ_I.wr_en && hit_misc;
  assign rail_mask_d = wr_rail ? REG_REQ_I.wdata : rail_mask_q;
  assign misc_mask_d = wr_misc ? REG_REQ_I.wdata : misc_mask_q;

  // Factory defaults are fixed per build variant, so they are constants here.
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rail_mask_q <= RAIL_RST;
      misc_mask_q <= MISC_RST;
    end else begin
      rail_mask_q <= rail_mask_d;
      misc_mask_q <= misc_mask_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  pgotm_pkg::pgotm_rsp_t rsp_d;
  wire                   acc;
  wire                   hit;

  assign acc            = REG_REQ_I.rd_en || REG_REQ_I.wr_en;
  assign hit            = hit_rail || hit_misc;
  assign rsp_d.rd_valid = REG_REQ_I.rd_en;
  assign rsp_d.rdata    = !REG_REQ_I.rd_en ? 8'h00 :
                          hit_rail ? rail_mask_q :
                          hit_misc ? misc_mask_q : 8'h00;
  assign rsp_d.err      = acc && !hit;

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RSP_O <= '0;
    end else begin
      REG_RSP_O <= rsp_d;
    end
  end

  // ----------------------------------------------------------------
  // Power-good tree
  // ----------------------------------------------------------------
  logic [7:0] rail_src;
  logic [7:0] misc_src;
  logic [7:0] rail_ok;
  logic [7:0] misc_ok;
  wire        tree_good;

  always_comb begin
    rail_src = '0;
    rail_src[pgotm_pkg::MASK_LINEAR_TWO]      = LINEAR_REG_TWO_PG_I;
    rail_src[pgotm_pkg::MASK_SWITCH_A_ONE]    = LOAD_SWITCH_A_ONE_PG_I;
    rail_src[pgotm_pkg::MASK_STEP_DOWN_SIX]   = STEP_DOWN_SIX_PG_I;
    rail_src[pgotm_pkg::MASK_STEP_DOWN_FIVE]  = STEP_DOWN_FIVE_PG_I;
    rail_src[pgotm_pkg::MASK_STEP_DOWN_FOUR]  = STEP_DOWN_FOUR_PG_I;
    rail_src[pgotm_pkg::MASK_STEP_DOWN_THREE] = STEP_DOWN_THREE_PG_I;
    rail_src[pgotm_pkg::MASK_STEP_DOWN_TWO]   = STEP_DOWN_TWO_PG_I;
    rail_src[pgotm_pkg::MASK_STEP_DOWN_ONE]   = STEP_DOWN_ONE_PG_I;
  end

  always_comb begin
    misc_src = '0;
    misc_src[pgotm_pkg::MASK_CONTROL_FIVE]    = ctl_sync[3];
    misc_src[pgotm_pkg::MASK_CONTROL_FOUR]    = ctl_sync[2];
    misc_src[pgotm_pkg::MASK_CONTROL_TWO]     = ctl_sync[1];
    misc_src[pgotm_pkg::MASK_CONTROL_ONE]     = ctl_sync[0];
    misc_src[pgotm_pkg::MASK_DDR_TERMINATION] = DDR_TERMINATION_REG_PG_I;
    misc_src[pgotm_pkg::MASK_SHARED_RAIL]     = SHARED_SWITCH_OR_LINEAR_RAIL_PG_I;
    misc_src[pgotm_pkg::MASK_SWITCH_B_ONE]    = LOAD_SWITCH_B_ONE_PG_I;
    misc_src[pgotm_pkg::MASK_LINEAR_THREE]    = LINEAR_REG_THREE_PG_I;
  end

  // A set mask bit forces its source to good, so it cannot pull the output low.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_gate
      assign rail_ok[g] = rail_src[g] | rail_mask_q[g];
      assign misc_ok[g] = misc_src[g] | misc_mask_q[g];
    end
  endgenerate

  assign tree_good = &{rail_ok, misc_ok};

  // Registered so the pin never glitches while sources change together.
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      STATUS_OUTPUT_THREE_O <= 1'b0;
      RAIL_MASK_O           <= 8'h00;
      MISC_MASK_O           <= 8'h00;
    end else begin
      STATUS_OUTPUT_THREE_O <= tree_good;
      RAIL_MASK_O           <= rail_mask_q;
      MISC_MASK_O           <= misc_mask_q;
    end
  end

endmodule : pgotm_top

// ==== core/pgotm_pkg.sv ====
package pgotm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RAIL_MASK_ADDR = 8'hAA;
  localparam logic [7:0] MISC_MASK_ADDR = 8'hAB;

  // ----------------------------------------------------------------
  // Field positions, rail mask register
  // ----------------------------------------------------------------
  localparam int MASK_STEP_DOWN_ONE   = 0;
  localparam int MASK_STEP_DOWN_TWO   = 1;
  localparam int MASK_STEP_DOWN_THREE = 2;
  localparam int MASK_STEP_DOWN_FOUR  = 3;
  localparam int MASK_STEP_DOWN_FIVE  = 4;
  localparam int MASK_STEP_DOWN_SIX   = 5;
  localparam int MASK_SWITCH_A_ONE    = 6;
  localparam int MASK_LINEAR_TWO      = 7;

  // ----------------------------------------------------------------
  // Field positions, misc mask register
  // ----------------------------------------------------------------
  localparam int MASK_LINEAR_THREE    = 0;
  localparam int MASK_SWITCH_B_ONE    = 1;
  localparam int MASK_SHARED_RAIL     = 2;
  localparam int MASK_DDR_TERMINATION = 3;
  localparam int MASK_CONTROL_ONE     = 4;
  localparam int MASK_CONTROL_TWO     = 5;
  localparam int MASK_CONTROL_FOUR    = 6;
  localparam int MASK_CONTROL_FIVE    = 7;

  // ----------------------------------------------------------------
  // Reset values per factory variant
  // ----------------------------------------------------------------
  localparam int NUM_VARIANTS = 4;
  localparam logic [7:0] RAIL_RESET [NUM_VARIANTS] = '{8'hE0, 8'h5C, 8'hF7, 8'hDF};
  localparam logic [7:0] MISC_RESET [NUM_VARIANTS] = '{8'hBF, 8'hEB, 8'hEF, 8'hDF};

  // Pin synchroniser depth.
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pgotm_req_t;

  typedef struct packed {
    logic       rd_valid;
    logic [7:0] rdata;
    logic       err;
  } pgotm_rsp_t;

endpackage : pgotm_pkg

// ==== core/pgotm_sync.sv ====
module pgotm_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  // Meta stage feeds only the second stage.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : pgotm_sync

// ==== tb/pgotm_watch.sv ====
module pgotm_watch (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Watched pin
  input  wire logic       status_i,
  output logic      [7:0] drops_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       prev_q;
  logic [7:0] drops_q;
  // A supervisor only logs falls of the good level, so a rise out of reset is not counted.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q  <= 1'b0;
      drops_q <= 8'h00;
    end else begin
      prev_q <= status_i;
      if (prev_q && !status_i) drops_q <= drops_q + 8'h01;
    end
  end
  assign drops_o = drops_q;
endmodule : pgotm_watch

// ==== tb/pgotm_assertions.sv ====
module pgotm_assertions (
  // Clock, reset and register port
  input wire logic       MCLK_I,
  input wire logic       RESET_N_I,
  input wire pgotm_pkg::pgotm_req_t REG_REQ_I,
  input wire pgotm_pkg::pgotm_rsp_t REG_RSP_O,
  // Sources
  input wire logic       STEP_DOWN_ONE_PG_I,
  input wire logic       STEP_DOWN_TWO_PG_I,
  input wire logic       STEP_DOWN_THREE_PG_I,
  input wire logic       STEP_DOWN_FOUR_PG_I,
  input wire logic       STEP_DOWN_FIVE_PG_I,
  input wire logic       STEP_DOWN_SIX_PG_I,
  input wire logic       LOAD_SWITCH_A_ONE_PG_I,
  input wire logic       LINEAR_REG_TWO_PG_I,
  input wire logic       LINEAR_REG_THREE_PG_I,
  input wire logic       LOAD_SWITCH_B_ONE_PG_I,
  input wire logic       SHARED_SWITCH_OR_LINEAR_RAIL_PG_I,
  input wire logic       DDR_TERMINATION_REG_PG_I,
  input wire logic       CONTROL_INPUT_ONE_I,
  input wire logic       CONTROL_INPUT_TWO_I,
  input wire logic       CONTROL_INPUT_FOUR_I,
  input wire logic       CONTROL_INPUT_FIVE_I,
  // Outputs
  input wire logic       STATUS_OUTPUT_THREE_O,
  input wire logic [7:0] RAIL_MASK_O,
  input wire logic [7:0] MISC_MASK_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rail_v;
  logic [3:0] misc_v;
  logic [3:0] ctl_v;
  logic [1:0] up_q;
  assign rail_v = {LINEAR_REG_TWO_PG_I, LOAD_SWITCH_A_ONE_PG_I, STEP_DOWN_SIX_PG_I,
                   STEP_DOWN_FIVE_PG_I, STEP_DOWN_FOUR_PG_I, STEP_DOWN_THREE_PG_I,
                   STEP_DOWN_TWO_PG_I, STEP_DOWN_ONE_PG_I};
  assign misc_v = {DDR_TERMINATION_REG_PG_I, SHARED_SWITCH_OR_LINEAR_RAIL_PG_I,
                   LOAD_SWITCH_B_ONE_PG_I, LINEAR_REG_THREE_PG_I};
  assign ctl_v  = {CONTROL_INPUT_FIVE_I, CONTROL_INPUT_FOUR_I, CONTROL_INPUT_TWO_I,
                   CONTROL_INPUT_ONE_I};
  // The pin synchroniser reads zero just after reset, so pin checks wait three edges.
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  rail_veto_a: assert property (|(~$past(rail_v) & ~RAIL_MASK_O) |-> !STATUS_OUTPUT_THREE_O)
    else $error("included rail fault did not clear the output");
  misc_veto_a: assert property (|(~$past(misc_v) & ~MISC_MASK_O[3:0]) |-> !STATUS_OUTPUT_THREE_O)
    else $error("included misc rail fault did not clear the output");
  pin_veto_a: assert property (up_q == 2'h3 && |(~$past(ctl_v, 3) & ~MISC_MASK_O[7:4])
    |-> !STATUS_OUTPUT_THREE_O) else $error("included low pin did not clear the output");
  all_good_a: assert property (up_q == 2'h3 && &($past(rail_v) | RAIL_MASK_O)
    && &($past(misc_v) | MISC_MASK_O[3:0]) && &($past(ctl_v, 3) | MISC_MASK_O[7:4])
    |-> STATUS_OUTPUT_THREE_O) else $error("output low with every included source good");
  rail_read_a: assert property (REG_REQ_I.rd_en && !REG_REQ_I.wr_en && REG_REQ_I.addr == 8'hAA
    |=> REG_RSP_O.rd_valid && REG_RSP_O.rdata == RAIL_MASK_O) else $error("rail mask read wrong");
  misc_read_a: assert property (REG_REQ_I.rd_en && !REG_REQ_I.wr_en && REG_REQ_I.addr == 8'hAB
    |=> REG_RSP_O.rd_valid && REG_RSP_O.rdata == MISC_MASK_O) else $error("misc mask read wrong");
  rail_write_a: assert property (REG_REQ_I.wr_en && REG_REQ_I.addr == 8'hAA
    |=> ##1 RAIL_MASK_O == $past(REG_REQ_I.wdata, 2)) else $error("rail mask write lost");
  misc_write_a: assert property (REG_REQ_I.wr_en && REG_REQ_I.addr == 8'hAB
    |=> ##1 MISC_MASK_O == $past(REG_REQ_I.wdata, 2)) else $error("misc mask write lost");
  bad_addr_a: assert property ((REG_REQ_I.wr_en || REG_REQ_I.rd_en) && REG_REQ_I.addr != 8'hAA
    && REG_REQ_I.addr != 8'hAB |=> REG_RSP_O.err && REG_RSP_O.rdata == 8'h00)
    else $error("unmapped access not flagged");
endmodule : pgotm_assertions

bind pgotm_top pgotm_assertions u_chk (.*);

// ==== tb/tb_pgotm_top.sv ====
module tb_pgotm_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, s) check_count++; if ((s) !== (e)) begin err_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [15:0]           src = 16'hFFFF;
  logic [7:0]            adr, rmask, mmask, drops;
  logic                  status;
  pgotm_pkg::pgotm_req_t req = '0;
  pgotm_pkg::pgotm_rsp_t rsp;
  int                    err_count = 0;
  int                    check_count = 0;
  always #10 clk = ~clk;
  pgotm_top #(.VARIANT(0)) dut (.MCLK_I(clk), .RESET_N_I(rst_n), .REG_REQ_I(req), .REG_RSP_O(rsp),
    .STEP_DOWN_ONE_PG_I(src[0]), .STEP_DOWN_TWO_PG_I(src[1]), .STEP_DOWN_THREE_PG_I(src[2]),
    .STEP_DOWN_FOUR_PG_I(src[3]), .STEP_DOWN_FIVE_PG_I(src[4]), .STEP_DOWN_SIX_PG_I(src[5]),
    .LOAD_SWITCH_A_ONE_PG_I(src[6]), .LINEAR_REG_TWO_PG_I(src[7]), .LINEAR_REG_THREE_PG_I(src[8]),
    .LOAD_SWITCH_B_ONE_PG_I(src[9]), .SHARED_SWITCH_OR_LINEAR_RAIL_PG_I(src[10]),
    .DDR_TERMINATION_REG_PG_I(src[11]), .CONTROL_INPUT_ONE_I(src[12]),
    .CONTROL_INPUT_TWO_I(src[13]), .CONTROL_INPUT_FOUR_I(src[14]), .CONTROL_INPUT_FIVE_I(src[15]),
    .STATUS_OUTPUT_THREE_O(status), .RAIL_MASK_O(rmask), .MISC_MASK_O(mmask));
  pgotm_watch u_watch (.clk_i(clk), .rst_n_i(rst_n), .status_i(status), .drops_o(drops));
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{wr_en: wr, rd_en: !wr, addr: a, wdata: d};
    @(posedge clk) req <= '0;
    #1;
  endtask : access
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    access(1'b0, a, 8'h00);
    `CHK("rdata", e, rsp.rdata)
    `CHK("rd_valid", 1'b1, rsp.rd_valid)
  endtask : rd_chk
  // Four edges cover the slowest path, a control pin through its synchroniser.
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(pgotm_pkg::RAIL_MASK_ADDR, pgotm_pkg::RAIL_RESET[0]);
    rd_chk(pgotm_pkg::MISC_MASK_ADDR, pgotm_pkg::MISC_RESET[0]);
    access(1'b1, pgotm_pkg::RAIL_MASK_ADDR, 8'h00);
    access(1'b1, pgotm_pkg::MISC_MASK_ADDR, 8'h00);
    settle;
    `CHK("all good", 1'b1, status)
    for (int i = 0; i < 16; i++) begin
      adr = (i < 8) ? pgotm_pkg::RAIL_MASK_ADDR : pgotm_pkg::MISC_MASK_ADDR;
      @(posedge clk) src[i] <= 1'b0;
      settle;
      `CHK("included drop", 1'b0, status)
      access(1'b1, adr, 8'h01 << (i % 8));
      settle;
      `CHK("masked drop", 1'b1, status)
      rd_chk(adr, 8'h01 << (i % 8));
      // Restore the source before unmasking it, so the pin does not fall a second time.
      @(posedge clk) src[i] <= 1'b1;
      settle;
      access(1'b1, adr, 8'h00);
      settle;
    end
    `CHK("watcher drops", 8'h10, drops)
    @(posedge clk) req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: 8'hAA, wdata: 8'hFF};
    @(posedge clk) req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: 8'hAB, wdata: 8'hFF};
    @(posedge clk) req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: 8'hAB, wdata: 8'h00};
    @(posedge clk) req <= '0;
    #1;
    `CHK("b2b read", 8'hFF, rsp.rdata)
    @(posedge clk) src <= 16'h0000;
    settle;
    `CHK("all masked", 1'b1, status)
    access(1'b1, 8'hAC, 8'h00);
    `CHK("bad wr err", 1'b1, rsp.err)
    access(1'b0, 8'hAC, 8'h00);
    `CHK("bad rd err", 1'b1, rsp.err)
    `CHK("bad rd data", 8'h00, rsp.rdata)
    rd_chk(pgotm_pkg::RAIL_MASK_ADDR, 8'hFF);
    close_out;
  end
  initial begin
    #100us;
    err_count++;
    close_out;
  end
endmodule : tb_pgotm_top
